// File: bench/pcl_control_lines_checker.sv
// Port assertions for the control line block
`timescale 1ns/1ps
module pcl_lines_checker
  import pcl_pkg::*;
(
  // Clock, reset, register port and strobes
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [PCL_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_port_a_read,
  input wire logic i_port_b_write,
  // Lines
  input wire logic i_side_a_event_input,
  input wire logic i_side_a_control_line,
  input wire logic o_side_a_control_line,
  input wire logic o_side_a_control_line_oe,
  input wire logic o_side_a_irq_n,
  input wire logic o_side_b_control_line,
  input wire logic o_side_b_control_line_oe
);
  logic [5:0] ca_q;
  logic [5:0] cb_q;
  // Shadow of the writable control bits
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ca_q <= 6'h00;
      cb_q <= 6'h00;
    end else if (i_write && i_addr == PCL_ADDR_W'(PCL_CTRL_A_OFS)) begin
      ca_q <= i_wdata[5:0];
    end else if (i_write && i_addr == PCL_ADDR_W'(PCL_CTRL_B_OFS)) begin
      cb_q <= i_wdata[5:0];
    end
  end
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_oe_from_bit5: assert property (
    o_side_a_control_line_oe == ca_q[5] && o_side_b_control_line_oe == cb_q[5]
  ) else $error("line enable wrong");
  a_manual_level: assert property (
    ca_q[5:4] == 2'b11 |-> o_side_a_control_line == ca_q[3]
  ) else $error("manual level wrong");
  a_pulse_a_read: assert property (
    ca_q[5:3] == 3'b101 && $past(ca_q[5:3]) == 3'b101 |->
    o_side_a_control_line == !$past(i_port_a_read)) else $error("a pulse");
  a_pulse_b_write: assert property (
    cb_q[5:3] == 3'b101 && $past(cb_q[5:3]) == 3'b101 |->
    o_side_b_control_line == !$past(i_port_b_write)) else $error("b pulse");
  a_event_irq_low: assert property (
    $past(i_rstn) && ca_q[1:0] == 2'b01 && $fell(i_side_a_event_input)
    |=> !o_side_a_irq_n) else $error("event irq missing");
  a_irq_needs_enable: assert property (
    !o_side_a_irq_n && $stable(ca_q) |-> ca_q[0] || (ca_q[3] && !ca_q[5])
  ) else $error("irq without enable");
  a_read_clears_a: assert property (
    i_port_a_read && $stable(i_side_a_event_input) &&
    $stable(i_side_a_control_line) |=> o_side_a_irq_n) else $error("clear");
  a_hs_write_low: assert property (
    cb_q[5:3] == 3'b100 && i_port_b_write |=> !o_side_b_control_line
  ) else $error("b handshake");
  cover property (ca_q[5:3] == 3'b101 && i_port_a_read);
  cover property (!o_side_a_irq_n);
  cover property (cb_q[5:3] == 3'b100 && i_port_b_write);
endmodule
bind pcl_control_lines pcl_lines_checker u_checker (.*);

// File: bench/pcl_control_lines_tb.sv
// Self-checking bench for the control line block
`timescale 1ns/1ps
module pcl_control_lines_tb;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [2:0] strb = 3'h0;
  logic [7:0] o_rdata;
  logic o_side_a_control_line, o_side_a_control_line_oe, o_side_a_irq_n;
  logic o_side_b_control_line, o_side_b_control_line_oe, o_side_b_irq_n;
  logic [3:0] lines;
  wire i_port_a_read = strb[0];
  wire i_port_b_read = strb[1];
  wire i_port_b_write = strb[2];
  wire i_side_a_event_input = lines[0];
  wire i_side_b_event_input = lines[2];
  wire i_side_a_control_line = o_side_a_control_line_oe ?
    o_side_a_control_line : lines[1];
  wire i_side_b_control_line = o_side_b_control_line_oe ?
    o_side_b_control_line : lines[3];
  int bad_count = 0;
  int n_checks = 0;
  always #25 i_clock = ~i_clock;
  pcl_control_lines dut (.*);
  pcl_periph_model pm (.i_clock(i_clock), .i_a_line(i_side_a_control_line),
    .i_b_line(i_side_b_control_line), .o_lines(lines));
  task chk(input logic ok, input string m);
    n_checks++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk(o_rdata === e, "read data");
  endtask
  task pulse(input int i);
    strb <= 3'(1 << i);
    @(posedge i_clock);
    strb <= 3'h0;
  endtask
  task conclude();
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h00);
    pm.put(0, 1'b0);
    repeat (2) @(posedge i_clock);
    rd(2'h0, 8'h80);
    chk(o_side_a_irq_n === 1'b1, "masked irq");
    pulse(0);
    wr(2'h0, 8'h01);
    pm.put(0, 1'b1);
    repeat (2) @(posedge i_clock);
    rd(2'h0, 8'h01);
    pm.put(0, 1'b0);
    repeat (2) @(posedge i_clock);
    #1 chk(o_side_a_irq_n === 1'b0, "event irq");
    pulse(0);
    #1 chk(o_side_a_irq_n === 1'b1, "read clear");
    wr(2'h0, 8'h03);
    pm.put(0, 1'b1);
    repeat (2) @(posedge i_clock);
    rd(2'h0, 8'h83);
    pulse(0);
    wr(2'h0, 8'h18);
    pm.put(1, 1'b0);
    pm.put(1, 1'b1);
    repeat (2) @(posedge i_clock);
    rd(2'h0, 8'h58);
    chk(o_side_a_irq_n === 1'b0, "line irq");
    pulse(0);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h3b);
    chk(o_side_a_control_line === 1'b1, "manual high");
    wr(2'h0, 8'h30);
    #1 chk(o_side_a_control_line === 1'b0, "manual low");
    wr(2'h0, 8'h28);
    pulse(0);
    #1 chk(o_side_a_control_line === 1'b0, "a pulse");
    @(posedge i_clock);
    #1 chk(o_side_a_control_line === 1'b1, "a pulse end");
    wr(2'h0, 8'h20);
    pulse(0);
    #1 chk(o_side_a_control_line === 1'b0, "a hs read");
    pm.offer_a();
    repeat (2) @(posedge i_clock);
    #1 chk(o_side_a_control_line === 1'b1, "a hs edge");
    rd(2'h0, 8'ha0);
    wr(2'h1, 8'h28);
    pulse(2);
    #1 chk(o_side_b_control_line === 1'b0, "b pulse");
    @(posedge i_clock);
    #1 chk(o_side_b_control_line === 1'b1, "b pulse end");
    repeat (4) @(posedge i_clock);
    rd(2'h1, 8'ha8);
    pulse(1);
    rd(2'h1, 8'h28);
    wr(2'h1, 8'h20);
    pulse(2);
    #1 chk(o_side_b_control_line === 1'b0, "b hs write");
    repeat (5) @(posedge i_clock);
    #1 chk(o_side_b_control_line === 1'b1, "b hs ack");
    chk(o_side_b_irq_n === 1'b1, "b irq masked");
    chk(o_side_b_control_line_oe === 1'b1, "b line enable");
    chk(o_side_a_control_line_oe === 1'b1, "a line enable");
    // Mid-run reset returns both sides to inputs with idle levels
    i_rstn <= 1'b0;
    @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    #1 chk(o_side_b_control_line_oe === 1'b0, "b oe after reset");
    chk(o_side_a_control_line_oe === 1'b0, "a oe after reset");
    chk(o_side_b_control_line === 1'b1, "b line after reset");
    chk(o_side_b_irq_n === 1'b1, "b irq after reset");
    rd(2'h1, 8'h00);
    conclude();
  end
endmodule

// File: bench/pcl_periph_model.sv
// Peripheral model driving the event inputs and input-mode lines
`timescale 1ns/1ps
module pcl_periph_model (
  // Clock and wire levels
  input wire logic i_clock,
  input wire logic i_a_line,
  input wire logic i_b_line,
  // Event a, line a, event b, line b
  output logic [3:0] o_lines
);
  initial o_lines = 4'hf;
  task put(input int idx, input logic v);
    @(posedge i_clock);
    o_lines[idx] <= v;
  endtask
  // Take B data on the falling line, then acknowledge with an edge
  always @(negedge i_b_line) begin
    repeat (2) @(posedge i_clock);
    o_lines[2] <= 1'b0;
    @(posedge i_clock);
    o_lines[2] <= 1'b1;
  end
  // New A data only once the line is low
  task offer_a();
    while (i_a_line) @(posedge i_clock);
    put(0, 1'b0);
    put(0, 1'b1);
  endtask
endmodule

// File: inc/pcl_pkg.sv
// Shared constants and types for the peripheral control line block
package pcl_pkg;

  // Register port
  localparam int unsigned PCL_ADDR_W = 2;
  localparam int unsigned PCL_CTRL_A_OFS = 0;
  localparam int unsigned PCL_CTRL_B_OFS = 1;

  // Values after reset
  localparam logic [7:0] PCL_CTRL_RESET = 8'h00;
  localparam logic PCL_LINE_RESET = 1'b1;
  localparam logic PCL_IRQ_N_RESET = 1'b1;
  localparam logic [7:0] PCL_RDATA_RESET = 8'h00;
  localparam logic PCL_EDGE_PREV_RESET = 1'b0;
  localparam logic PCL_EDGE_PRIMED_RESET = 1'b0;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic event_flag;     // Bit 7, set by event input edge
    logic line_flag;      // Bit 6, set by control line edge (input mode)
    logic line_output;    // Bit 5, control line is an output
    logic line_sel4;      // Bit 4, edge select or manual mode
    logic line_sel3;      // Bit 3, irq enable or output sub-mode
    logic reserved2;      // Bit 2, reads as zero
    logic event_rise;     // Bit 1, event input edge select
    logic event_irq_en;   // Bit 0, event flag irq enable
  } pcl_ctrl_s;

  // Output behaviour of the second control line
  typedef enum logic [1:0] {
    PCL_OUT_HANDSHAKE,
    PCL_OUT_PULSE,
    PCL_OUT_MANUAL
  } pcl_out_mode_e;

  // State of one side
  typedef struct packed {
    pcl_ctrl_s ctrl;
    logic line;
    logic irq_n;
  } pcl_side_s;

  // Whole state of the top module
  typedef struct packed {
    pcl_side_s a;
    pcl_side_s b;
    logic [7:0] rdata;
  } pcl_state_s;

  // State of one edge detector
  typedef struct packed {
    logic prev;
    logic primed;
  } pcl_edge_s;

endpackage

// File: src/pcl_control_lines.sv
// Interrupt input and peripheral control lines for sides A and B
//
// Operation
// - First control line is input only
// - Control bit 1 selects event input edge
// - Event input edge sets flag bit 7
// - Bit 0 gates flag 7 onto irq
// - Bit 5 clear: line input, bit 4 edge
// - Input mode line edge sets flag 6
// - Bit 3 gates flag 6 onto irq
// - Data port read clears both flags
// - Bit 5 set: line driven as output
// - A handshake: edge high, read low
// - A pulse: low one cycle after read
// - Manual mode: line follows bit 3
// - B handshake: write low, edge high
// - B pulse: low one cycle after write
`timescale 1ns/1ps
module pcl_control_lines
  import pcl_pkg::*;
#(
  parameter int unsigned ADDR_W = PCL_ADDR_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  // Data port strobes from the port logic
  input wire logic i_port_a_read,
  input wire logic i_port_b_read,
  input wire logic i_port_b_write,
  // Side A lines
  input wire logic i_side_a_event_input,
  input wire logic i_side_a_control_line,
  output logic o_side_a_control_line,
  output logic o_side_a_control_line_oe,
  output logic o_side_a_irq_n,
  // Side B lines
  input wire logic i_side_b_event_input,
  input wire logic i_side_b_control_line,
  output logic o_side_b_control_line,
  output logic o_side_b_control_line_oe,
  output logic o_side_b_irq_n
);

  generate
    if (ADDR_W < 1) begin : g_bad_addr
      $error("ADDR_W must be at least 1");
    end
  endgenerate

  localparam logic [ADDR_W-1:0] CTRL_A_ADDR = ADDR_W'(PCL_CTRL_A_OFS);
  localparam logic [ADDR_W-1:0] CTRL_B_ADDR = ADDR_W'(PCL_CTRL_B_OFS);

  pcl_state_s state_q;
  pcl_state_s state_d;

  logic a_event_edge;
  logic a_line_edge;
  logic b_event_edge;
  logic b_line_edge;

  // Output mode from bits 4 and 3
  function automatic pcl_out_mode_e out_mode(input pcl_ctrl_s c);
    pcl_out_mode_e m;
    if (c.line_sel4) begin
      m = PCL_OUT_MANUAL;
    end else if (c.line_sel3) begin
      m = PCL_OUT_PULSE;
    end else begin
      m = PCL_OUT_HANDSHAKE;
    end
    return m;
  endfunction

  // Next state of one side; strobe is the side's data port event
  function automatic pcl_side_s side_next(
    input pcl_side_s cur,
    input logic wr_ctrl,
    input logic [7:0] wdata,
    input logic clr,
    input logic ev_edge,
    input logic ln_edge,
    input logic strobe
  );
    pcl_side_s nx;
    pcl_ctrl_s w;
    nx = cur;
    w = pcl_ctrl_s'(wdata);
    // Flags are read only; reserved bit stays zero
    if (wr_ctrl) begin
      nx.ctrl.line_output = w.line_output;
      nx.ctrl.line_sel4 = w.line_sel4;
      nx.ctrl.line_sel3 = w.line_sel3;
      nx.ctrl.event_rise = w.event_rise;
      nx.ctrl.event_irq_en = w.event_irq_en;
    end
    nx.ctrl.reserved2 = 1'b0;
    if (clr) begin
      nx.ctrl.event_flag = 1'b0;
      nx.ctrl.line_flag = 1'b0;
    end
    // A set in the same cycle as the clearing read wins
    if (ev_edge) begin
      nx.ctrl.event_flag = 1'b1;
    end
    if (ln_edge && !cur.ctrl.line_output) begin
      nx.ctrl.line_flag = 1'b1;
    end
    if (nx.ctrl.line_output) begin
      unique case (out_mode(nx.ctrl))
        PCL_OUT_MANUAL: begin
          nx.line = nx.ctrl.line_sel3;
        end
        PCL_OUT_PULSE: begin
          nx.line = !strobe;
        end
        PCL_OUT_HANDSHAKE: begin
          if (strobe) begin
            nx.line = 1'b0;
          end else if (ev_edge) begin
            nx.line = 1'b1;
          end
        end
      endcase
    end else begin
      nx.line = PCL_LINE_RESET;
    end
    nx.irq_n = !((nx.ctrl.event_flag && nx.ctrl.event_irq_en)
      || (nx.ctrl.line_flag && nx.ctrl.line_sel3
      && !nx.ctrl.line_output));
    return nx;
  endfunction

  // Event inputs are only ever sampled, never driven
  pcl_edge u_a_event (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_level(i_side_a_event_input),
    .i_rise_sel(state_q.a.ctrl.event_rise),
    .o_edge(a_event_edge)
  );

  pcl_edge u_a_line (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_level(i_side_a_control_line),
    .i_rise_sel(state_q.a.ctrl.line_sel4),
    .o_edge(a_line_edge)
  );

  pcl_edge u_b_event (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_level(i_side_b_event_input),
    .i_rise_sel(state_q.b.ctrl.event_rise),
    .o_edge(b_event_edge)
  );

  pcl_edge u_b_line (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_level(i_side_b_control_line),
    .i_rise_sel(state_q.b.ctrl.line_sel4),
    .o_edge(b_line_edge)
  );

  always_comb begin
    state_d = state_q;
    state_d.a = side_next(state_q.a,
      i_write && (i_addr == CTRL_A_ADDR), i_wdata,
      i_port_a_read, a_event_edge, a_line_edge, i_port_a_read);
    state_d.b = side_next(state_q.b,
      i_write && (i_addr == CTRL_B_ADDR), i_wdata,
      i_port_b_read, b_event_edge, b_line_edge, i_port_b_write);
    // Read data stand only in the cycle after the strobe
    state_d.rdata = PCL_RDATA_RESET;
    if (i_read) begin
      if (i_addr == CTRL_A_ADDR) begin
        state_d.rdata = state_q.a.ctrl;
      end else if (i_addr == CTRL_B_ADDR) begin
        state_d.rdata = state_q.b.ctrl;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q.a.ctrl <= PCL_CTRL_RESET;
      state_q.a.line <= PCL_LINE_RESET;
      state_q.a.irq_n <= PCL_IRQ_N_RESET;
      state_q.b.ctrl <= PCL_CTRL_RESET;
      state_q.b.line <= PCL_LINE_RESET;
      state_q.b.irq_n <= PCL_IRQ_N_RESET;
      state_q.rdata <= PCL_RDATA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata = state_q.rdata;
  assign o_side_a_control_line = state_q.a.line;
  assign o_side_a_control_line_oe = state_q.a.ctrl.line_output;
  assign o_side_a_irq_n = state_q.a.irq_n;
  assign o_side_b_control_line = state_q.b.line;
  assign o_side_b_control_line_oe = state_q.b.ctrl.line_output;
  assign o_side_b_irq_n = state_q.b.irq_n;

endmodule

// File: src/pcl_edge.sv
// Edge detector for one control input, selectable polarity
`timescale 1ns/1ps
module pcl_edge
  import pcl_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Line and edge select
  input wire logic i_level,
  input wire logic i_rise_sel,
  // Detected edge, combinational
  output logic o_edge
);

  pcl_edge_s state_q;
  pcl_edge_s state_d;

  // No edge is reported before a first sample exists
  always_comb begin
    state_d = state_q;
    state_d.prev = i_level;
    state_d.primed = 1'b1;
    o_edge = 1'b0;
    if (state_q.primed) begin
      if (i_rise_sel) begin
        o_edge = !state_q.prev && i_level;
      end else begin
        o_edge = state_q.prev && !i_level;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q.prev <= PCL_EDGE_PREV_RESET;
      state_q.primed <= PCL_EDGE_PRIMED_RESET;
    end else begin
      state_q <= state_d;
    end
  end

endmodule
